// *** design/umd_pkg.sv ***
// Summary of operation
// - Normal multidrop runs when multidrop bit is set and special detection is off.
// - Normal multidrop, receiver off: drop data, store address bytes with parity error.
// - Normal multidrop, receiver on: keep data, line status interrupt per address byte.
// - Automatic address mode runs when multidrop bit and special detection are set.
// - Automatic mode compares address bytes with the second flow-off character; discards others.
// - Matching address enables receiver, is stored with ninth bit as parity error.
// - Enabled receiver seeing a foreign address disables itself until next match.
// - Divisor bytes and fraction field are reachable only while divisor access is set.
// - Direction pin is high in transmit when polarity bit is 0, inverted otherwise.
// - With parity check set, flow characters with parity errors are rejected.
// - Infrared pulses are 3/16 bit wide, or 1/4 bit with fast infrared set.
// - Receive-available interrupt and status follow queue level against the trigger while queues are enabled.
// - Data ready sets when a character enters the queue, clears when empty.
// - Line status bits support polling with queues enabled and low enables cleared.
// - Rising clear-to-send input and request-to-send output interrupt, needing enhanced bit.
// - Enable bit 5 gates the flow-off interrupt; bit 4 reserved; enables reset to 0.
// - Modem interrupt fires whenever any of the four delta bits becomes set.
// - Errored character interrupts on arrival and again on reaching the queue head.
// - Transmit-ready fires on empty holding; with queues below trigger, then empty.
// - Receive-ready fires on a held character, or trigger level with queues.
package umd_pkg;
    // Byte addresses of the register words.
    localparam logic [7:0] OFF_DATA  = 8'h00;
    localparam logic [7:0] OFF_IEN   = 8'h04;
    localparam logic [7:0] OFF_LCTL  = 8'h08;
    localparam logic [7:0] OFF_LSTAT = 8'h0C;
    localparam logic [7:0] OFF_MSTAT = 8'h10;
    localparam logic [7:0] OFF_EFR   = 8'h14;
    localparam logic [7:0] OFF_QCTL  = 8'h18;
    localparam logic [7:0] OFF_TRIG  = 8'h1C;
    localparam logic [7:0] OFF_FCTL  = 8'h20;
    localparam logic [7:0] OFF_SECOND_FLOW_OFF_CHAR = 8'h24;
    localparam logic [7:0] OFF_DLL   = 8'h28;
    localparam logic [7:0] OFF_DLM   = 8'h2C;
    localparam logic [7:0] OFF_FDM   = 8'h30;
    localparam logic [7:0] OFF_ISRC  = 8'h34;
    // Field positions.
    localparam int FDM_POL   = 7;
    localparam int FDM_MD    = 6;
    localparam int FDM_FPAR  = 5;
    localparam int FDM_FIR   = 4;
    localparam int EFR_SPEC  = 5;
    localparam int EFR_ENH   = 4;
    localparam int LCTL_DIV  = 7;
    localparam int MST_RXOFF = 2;
    localparam int QCTL_EN   = 0;
    localparam int QCTL_RRST = 1;
    localparam int FCTL_HD   = 5;
    localparam int FCTL_IR   = 2;
    // Reset values and masks.
    localparam logic [7:0] RST_REG  = 8'h00;
    localparam logic [7:0] RST_DLL  = 8'h01;
    localparam logic [7:0] RST_TRIG = 8'h01;
    localparam logic [7:0] IEN_MASK = 8'hEF;
    localparam logic [3:0] RST_PINS = 4'hF;
    // Receive queue shape.
    localparam int         QAW      = 4;
    localparam int         QDEPTH   = 16;
    localparam logic [4:0] QCAP_ALL = 5'h10;
    localparam logic [4:0] QCAP_ONE = 5'h01;
    // Infrared pulse widths in 16x ticks.
    localparam logic [2:0] IR_SLOW  = 3'h3;
    localparam logic [2:0] IR_FAST  = 3'h4;
    // Bus responses.
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// *** design/umd_top.sv ***
module umd_top
    import umd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_ninth,
    input  wire logic        rx_parity_err,
    input  wire logic        rx_frame_err,
    input  wire logic        rx_break,
    input  wire logic        tx_empty,
    input  wire logic        tx_below_trig,
    input  wire logic        tx_shift_empty,
    input  wire logic        tx_active,
    input  wire logic        tx_bit_start,
    input  wire logic        tx_bit,
    input  wire logic        rts_n_level,
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ri_n,
    input  wire logic        cd_n,
    output logic             irq,
    output logic             dir_out,
    output logic             ir_out,
    output logic [7:0]       tx_data,
    output logic             tx_load,
    output logic             baud_tick
);

    // A low-to-high step between two samples.
    function automatic logic umd_rise(input logic old_v, input logic new_v);
        return ~old_v & new_v;
    endfunction

    // Whether a byte address holds a register word.
    function automatic logic umd_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFF_ISRC);
    endfunction

    logic [7:0]     ien;
    logic [7:0]     lctl;
    logic [7:0]     enhanced_feature_register;
    logic           qen;
    logic [7:0]     trig;
    logic [7:0]     fctl;
    logic [7:0]     second_flow_off_char;
    logic [7:0]     dll;
    logic [7:0]     divisor_high_byte;
    logic [7:0]     fdm;
    logic           rx_off;
    logic           auto_en;
    logic           aw_q;
    logic           w_q;
    logic [7:0]     awa;
    logic [7:0]     wd;
    logic           wlane;
    logic [10:0]    q_mem [0:QDEPTH-1];
    logic [QAW-1:0] wr_ptr;
    logic [QAW-1:0] rd_ptr;
    logic [4:0]     q_cnt;
    logic [4:0]     err_cnt;
    logic           overrun;
    logic           lsr_p;
    logic           tx_p;
    logic           xoff_p;
    logic           cts_p;
    logic           rts_p;
    logic [3:0]     delta;
    logic [3:0]     s1;
    logic [3:0]     s2;
    logic [3:0]     s3;
    logic [3:0]     pin_q;
    logic           rts_q;
    logic           txe_q;
    logic           txb_q;
    logic           txs_q;
    logic [15:0]    bcnt;
    logic [3:0]     facc;
    logic [2:0]     ir_cnt;
    logic [7:0]     rd_val;

    // Bus handshakes and decoded accesses.
    wire ar_hs  = arvalid & arready;
    wire do_wr  = aw_q & w_q & ~bvalid;
    wire wr_en  = do_wr & wlane & umd_mapped(awa);
    wire div_ok = lctl[LCTL_DIV];
    wire wr_data  = wr_en & (awa == OFF_DATA);
    wire rd_data  = ar_hs & (araddr == OFF_DATA);
    wire rd_lstat = ar_hs & (araddr == OFF_LSTAT);
    wire rd_mstat = ar_hs & (araddr == OFF_MSTAT);
    wire rd_isrc  = ar_hs & (araddr == OFF_ISRC);
    wire rx_rst   = wr_en & (awa == OFF_QCTL) & wd[QCTL_RRST] & wd[QCTL_EN];

    // Address filtering of the incoming character stream.
    wire md_on    = fdm[FDM_MD];
    wire auto_md  = md_on & enhanced_feature_register[EFR_SPEC];
    wire norm_md  = md_on & ~enhanced_feature_register[EFR_SPEC];
    wire is_addr  = rx_ninth;
    wire addr_hit = (rx_data == second_flow_off_char);
    wire acc_norm = is_addr | ~rx_off;
    wire acc_auto = is_addr ? addr_hit : auto_en;
    wire accept   = ~md_on | (norm_md & acc_norm) | (auto_md & acc_auto);
    wire in_perr  = md_on ? is_addr : rx_parity_err;
    wire in_err   = in_perr | rx_frame_err | rx_break;

    // Queue occupancy; without queues only one character is held.
    wire [4:0] cap   = qen ? QCAP_ALL : QCAP_ONE;
    wire       full  = (q_cnt >= cap);
    wire       req   = rx_valid & accept;
    wire       push  = req & ~full;
    wire       pop   = rd_data & (q_cnt != 5'h00);
    wire [10:0] head = q_mem[rd_ptr];
    wire [10:0] nxt  = q_mem[rd_ptr + 4'h1];
    wire       h_err = (q_cnt != 5'h00) & (|head[10:8]);
    wire       n_err = (q_cnt > 5'h01) & (|nxt[10:8]);

    // Flow-off character seen outside multidrop operation.
    wire flow_hit = rx_valid & ~md_on & (rx_data == second_flow_off_char) & ~(fdm[FDM_FPAR] & rx_parity_err);

    // Modem pins: a bit changes only when the second and third stages agree.
    wire [3:0] pin_nx = (s2 & s3) | (pin_q & (s2 ^ s3));
    wire [3:0] chg    = pin_nx ^ pin_q;
    wire [3:0] d_set  = {chg[3], umd_rise(pin_q[2], pin_nx[2]), chg[1], chg[0]};
    wire       cts_up = umd_rise(pin_q[0], pin_nx[0]);
    wire       rts_up = umd_rise(rts_q, rts_n_level);

    // Transmit-ready sources; with queues enabled, half duplex waits for the shifter to drain.
    wire tx_sec = fctl[FCTL_HD] ? (tx_empty & tx_shift_empty) : tx_empty;
    wire tx_q_ev = umd_rise(txb_q, tx_below_trig) | umd_rise(txs_q, tx_sec);
    wire tx_set  = qen ? tx_q_ev : umd_rise(txe_q, tx_empty);
    wire tx_clr  = rd_isrc | wr_data;

    // Receive-ready level against the trigger.
    wire rxrdy = qen ? ({3'h0, q_cnt} >= trig) : (q_cnt != 5'h00);

    // Line status in polled form.
    wire [7:0] lstat = {err_cnt != 5'h00, tx_empty & tx_shift_empty, tx_empty,
                        h_err & head[10], h_err & head[9], h_err & head[8],
                        overrun, q_cnt != 5'h00};

    // Effective enables; the upper three need the enhanced bit.
    wire enh = enhanced_feature_register[EFR_ENH];
    wire next_irq = (ien[2] & lsr_p) | (ien[0] & rxrdy) | (ien[1] & tx_p)
                  | (ien[3] & (|delta))
                  | (enh & ien[5] & xoff_p)
                  | (enh & ((ien[7] & cts_p) | (ien[6] & rts_p)));

    // Line status event: errored arrival, overrun, or errored character becoming head.
    wire lsr_set = (push & in_err) | (req & full) | (pop & n_err);

    // Baud divider with fractional stretch of one cycle per carry.
    wire [15:0] div    = {divisor_high_byte, dll};
    wire [15:0] div_m1 = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
    wire [4:0]  fsum   = {1'b0, facc} + {1'b0, fdm[3:0]};
    wire [15:0] reload = div_m1 + {15'h0000, fsum[4]};

    // Infrared pulse length.
    wire [2:0] ir_w = fdm[FDM_FIR] ? IR_FAST : IR_SLOW;
    wire       ir_go = fctl[FCTL_IR] & tx_bit_start & ~tx_bit;
    wire [2:0] next_ir_cnt = ir_go ? ir_w :
                             (baud_tick & (ir_cnt != 3'h0)) ? ir_cnt - 3'h1 : ir_cnt;

    // Read selection; divisor words read as zero while access is closed.
    always_comb begin
        unique case (araddr)
            OFF_DATA:  rd_val = (q_cnt != 5'h00) ? head[7:0] : 8'h00;
            OFF_IEN:   rd_val = ien;
            OFF_LCTL:  rd_val = lctl;
            OFF_LSTAT: rd_val = lstat;
            OFF_MSTAT: rd_val = {~pin_q, delta};
            OFF_EFR:   rd_val = enhanced_feature_register;
            OFF_QCTL:  rd_val = {7'h00, qen};
            OFF_TRIG:  rd_val = trig;
            OFF_FCTL:  rd_val = fctl;
            OFF_SECOND_FLOW_OFF_CHAR: rd_val = second_flow_off_char;
            OFF_DLL:   rd_val = div_ok ? dll : 8'h00;
            OFF_DLM:   rd_val = div_ok ? divisor_high_byte : 8'h00;
            OFF_FDM:   rd_val = div_ok ? fdm : 8'h00;
            OFF_ISRC:  rd_val = {irq, rts_p, cts_p, xoff_p, |delta, tx_p, rxrdy, lsr_p};
            default:   rd_val = 8'h00;
        endcase
    end

    // Write channel capture; address and data may arrive in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q    <= 1'b0;
            w_q     <= 1'b0;
            awa     <= 8'h00;
            wd      <= 8'h00;
            wlane   <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OK;
        end else begin
            if (awvalid & awready) begin
                aw_q    <= 1'b1;
                awa     <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid & wready) begin
                w_q    <= 1'b1;
                wd     <= wdata[7:0];
                wlane  <= wstrb[0];
                wready <= 1'b0;
            end
            if (do_wr) begin
                aw_q   <= 1'b0;
                w_q    <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= umd_mapped(awa) ? RESP_OK : RESP_ERR;
            end
            if (bvalid & bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Read channel; data is captured at the address handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OK;
        end else if (ar_hs) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_val};
            rresp   <= umd_mapped(araddr) ? RESP_OK : RESP_ERR;
        end else if (rvalid & rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Configuration registers; the reserved enable bit is never stored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien    <= RST_REG;
            lctl   <= RST_REG;
            enhanced_feature_register    <= RST_REG;
            qen    <= 1'b0;
            trig   <= RST_TRIG;
            fctl   <= RST_REG;
            second_flow_off_char  <= RST_REG;
            dll    <= RST_DLL;
            divisor_high_byte    <= RST_REG;
            fdm    <= RST_REG;
            rx_off <= 1'b0;
        end else if (wr_en) begin
            unique case (awa)
                OFF_IEN:   ien <= wd & IEN_MASK;
                OFF_LCTL:  lctl <= wd;
                OFF_EFR:   enhanced_feature_register <= wd;
                OFF_QCTL:  qen <= wd[QCTL_EN];
                OFF_TRIG:  trig <= wd;
                OFF_FCTL:  fctl <= wd;
                OFF_SECOND_FLOW_OFF_CHAR: second_flow_off_char <= wd;
                OFF_MSTAT: rx_off <= wd[MST_RXOFF];
                OFF_DLL:   dll <= div_ok ? wd : dll;
                OFF_DLM:   divisor_high_byte <= div_ok ? wd : divisor_high_byte;
                OFF_FDM:   fdm <= div_ok ? wd : fdm;
                default:   ;
            endcase
        end
    end

    // Automatic address state: a match opens, a foreign address closes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_en <= 1'b0;
        end else if (rx_valid & auto_md & is_addr) begin
            auto_en <= addr_hit;
        end
    end

    // Receive queue storage; entries hold break, framing, parity and data.
    always_ff @(posedge aclk) begin
        if (push) begin
            q_mem[wr_ptr] <= {rx_break, rx_frame_err, in_perr, rx_data};
        end
    end

    // Queue pointers and counters; a reset of the queue leaves the shifter alone.
    always_ff @(posedge aclk) begin
        if (!aresetn || rx_rst) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            q_cnt   <= 5'h00;
            err_cnt <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 4'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 4'h1;
            end
            q_cnt   <= q_cnt + {4'h0, push} - {4'h0, pop};
            err_cnt <= err_cnt + {4'h0, push & in_err} - {4'h0, pop & h_err};
        end
    end

    // Sticky event flags; a set in the clearing cycle wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun <= 1'b0;
            lsr_p   <= 1'b0;
            tx_p    <= 1'b0;
            xoff_p  <= 1'b0;
            cts_p   <= 1'b0;
            rts_p   <= 1'b0;
            delta   <= 4'h0;
        end else begin
            overrun <= (req & full) | (overrun & ~rd_lstat);
            lsr_p   <= lsr_set | (lsr_p & ~rd_lstat);
            tx_p    <= tx_set | (tx_p & ~tx_clr);
            xoff_p  <= flow_hit | (xoff_p & ~rd_isrc);
            cts_p   <= cts_up | (cts_p & ~rd_mstat);
            rts_p   <= rts_up | (rts_p & ~rd_mstat);
            delta   <= d_set | (delta & {4{~rd_mstat}});
        end
    end

    // Three-stage pin synchronisers and the filtered pin levels.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1    <= RST_PINS;
            s2    <= RST_PINS;
            s3    <= RST_PINS;
            pin_q <= RST_PINS;
        end else begin
            s1    <= {cd_n, ri_n, dsr_n, cts_n};
            s2    <= s1;
            s3    <= s2;
            pin_q <= pin_nx;
        end
    end

    // Previous samples for edge detection on same-clock inputs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rts_q <= 1'b1; // Idle level of the pin.
            txe_q <= 1'b0;
            txb_q <= 1'b0;
            txs_q <= 1'b0;
        end else begin
            rts_q <= rts_n_level;
            txe_q <= tx_empty;
            txb_q <= tx_below_trig;
            txs_q <= tx_sec;
        end
    end

    // Baud tick generator at the 16x rate.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bcnt      <= 16'h0000;
            facc      <= 4'h0;
            baud_tick <= 1'b0;
        end else if (bcnt == 16'h0000) begin
            bcnt      <= reload;
            facc      <= fsum[3:0];
            baud_tick <= 1'b1;
        end else begin
            bcnt      <= bcnt - 16'h0001;
            baud_tick <= 1'b0;
        end
    end

    // Pin outputs; direction follows the transmitter, inverted by polarity.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ir_cnt  <= 3'h0;
            ir_out  <= 1'b0;
            dir_out <= 1'b0;
            irq     <= 1'b0;
            tx_data <= 8'h00;
            tx_load <= 1'b0;
        end else begin
            ir_cnt  <= next_ir_cnt;
            ir_out  <= next_ir_cnt != 3'h0;
            dir_out <= tx_active ^ fdm[FDM_POL];
            irq     <= next_irq;
            tx_data <= wr_data ? wd : tx_data;
            tx_load <= wr_data;
        end
    end

endmodule

// *** tb/umd_monitor.sv ***
module umd_monitor
    import umd_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        tx_active,
    input wire logic        irq,
    input wire logic        dir_out,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_load
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wbyte;

    // Only the low byte of a write carries register data.
    assign wbyte = wdata[7:0];

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Both write channels taken at one edge, and a read request taken.
    sequence s_wr_both;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence

    a_write_answer: assert property (s_wr_both |=> !awready && !wready ##1 bvalid)
        else $error("write not answered in time");
    a_write_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write slot not freed after response");
    a_read_answer: assert property (s_rd_take |=> rvalid && !arready)
        else $error("read not answered one cycle later");
    a_read_release: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read slot not freed after response");
    a_rdata_high_zero: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    a_unmapped_error: assert property (s_rd_take ##0 araddr > OFF_ISRC |=> rresp == RESP_ERR)
        else $error("unmapped read not refused");
    a_tx_byte_load: assert property (s_wr_both ##0 awaddr == OFF_DATA && wstrb[0]
        |=> ##1 tx_load && tx_data == $past(wbyte, 2))
        else $error("transmit byte not loaded");
    a_tx_load_once: assert property (tx_load |-> $rose(bvalid))
        else $error("transmit load without write response");
    a_dir_follow: assert property ($changed(tx_active) |=> dir_out != $past(dir_out))
        else $error("direction pin did not follow transmit activity");
    a_irq_quiet_reset: assert property ($rose(aresetn) |-> !irq)
        else $error("interrupt active right after reset");
endmodule

bind umd_top umd_monitor i_umd_monitor (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .tx_active, .irq, .dir_out, .tx_data, .tx_load);

// *** tb/umd_station.sv ***
module umd_station (
    input  wire logic       aclk,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_ninth,
    output logic            rx_parity_err,
    output logic            rx_frame_err,
    output logic            rx_break
);
    timeunit 1ns;
    timeprecision 1ns;

    // The station never sends framing faults or breaks in these tests.
    initial begin
        {rx_valid, rx_ninth, rx_parity_err, rx_frame_err, rx_break} = '0;
        rx_data = 8'h00;
    end

    // One character per call; idle lines show the inverse.
    task automatic send(input logic adr, input logic [7:0] b);
        @(posedge aclk);
        rx_valid <= 1'b1;
        rx_data <= b;
        rx_ninth <= adr;
        rx_parity_err <= adr;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        rx_ninth <= ~adr;
        rx_parity_err <= ~adr;
    endtask
endmodule

// *** tb/umd_top_tb.sv ***
module umd_top_tb
    import umd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0;
    logic        aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic        tx_empty, tx_below_trig, tx_shift_empty, tx_active, tx_bit_start, tx_bit, rts_n_level;
    logic        cts_n, dsr_n, ri_n, cd_n, irq, dir_out, ir_out, tx_load, baud_tick;
    logic        rx_valid, rx_ninth, rx_parity_err, rx_frame_err, rx_break;
    logic [7:0]  awaddr, araddr, rx_data, tx_data;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          n_errors = 0;
    int          checks = 0;

    umd_top i_umd_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .rx_valid, .rx_data, .rx_ninth, .rx_parity_err, .rx_frame_err, .rx_break, .tx_empty,
        .tx_below_trig, .tx_shift_empty, .tx_active, .tx_bit_start, .tx_bit, .rts_n_level, .cts_n,
        .dsr_n, .ri_n, .cd_n, .irq, .dir_out, .ir_out, .tx_data, .tx_load, .baud_tick);
    umd_station i_umd_station (.aclk, .rx_valid, .rx_data, .rx_ninth, .rx_parity_err, .rx_frame_err,
        .rx_break);

    always #20 aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Address and data go out together; each drops once taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit aw_done = 0;
        bit w_done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
    endtask

    // Both response ready inputs stay high all run.
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OK);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk({22'h0, rresp, rdata[7:0]}, {22'h0, r, e});
    endtask

    task automatic irq_is(input logic e, input int n);
        repeat (n) @(negedge aclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    initial begin
        {aresetn, awvalid, wvalid, arvalid, tx_empty, tx_below_trig, tx_shift_empty, tx_active} = '0;
        {tx_bit_start, tx_bit} = '0;
        {bready, rready, rts_n_level, cts_n, dsr_n, ri_n, cd_n} = '1;
        {awaddr, araddr, wdata, wstrb} = {48'h0, 4'hF};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rc(OFF_IEN, 8'h00);
        wr(OFF_IEN, 8'hFF);
        rc(OFF_IEN, 8'hEF);
        rc(8'h38, 8'h00, RESP_ERR);
        wr(OFF_DATA, 8'hA5);
        wr(OFF_DLM, 8'h12);
        wr(OFF_LCTL, 8'h80);
        rc(OFF_DLL, 8'h01);
        rc(OFF_DLM, 8'h00);
        wr(OFF_FDM, 8'hC0);
        tx_active <= 1'b1;
        repeat (3) @(negedge aclk);
        chk({31'h0, dir_out}, 32'h0000_0000);
        wr(OFF_FDM, 8'h40);
        repeat (3) @(negedge aclk);
        chk({31'h0, dir_out}, 32'h0000_0001);
        tx_active <= 1'b0;
        wr(OFF_LCTL, 8'h38);
        rc(OFF_FDM, 8'h00);
        // Normal multidrop with the receiver held off, then opened by software.
        wr(OFF_QCTL, 8'h01);
        wr(OFF_IEN, 8'h04);
        wr(OFF_MSTAT, 8'h04);
        i_umd_station.send(1'b0, 8'h11);
        i_umd_station.send(1'b1, 8'h5A);
        irq_is(1'b1, 4);
        rc(OFF_LSTAT, 8'h85);
        rc(OFF_DATA, 8'h5A);
        rc(OFF_LSTAT, 8'h00);
        wr(OFF_MSTAT, 8'h00);
        i_umd_station.send(1'b0, 8'h22);
        i_umd_station.send(1'b1, 8'h33);
        irq_is(1'b1, 4);
        rc(OFF_LSTAT, 8'h81);
        irq_is(1'b0, 3);
        rc(OFF_DATA, 8'h22);
        irq_is(1'b1, 3);
        rc(OFF_LSTAT, 8'h85);
        rc(OFF_DATA, 8'h33);
        rc(OFF_LSTAT, 8'h00);
        // Automatic address matching against the second flow-off character.
        wr(OFF_EFR, 8'h20);
        wr(OFF_SECOND_FLOW_OFF_CHAR, 8'h5A);
        i_umd_station.send(1'b0, 8'h44);
        i_umd_station.send(1'b1, 8'h12);
        i_umd_station.send(1'b1, 8'h5A);
        i_umd_station.send(1'b0, 8'h66);
        i_umd_station.send(1'b1, 8'h13);
        i_umd_station.send(1'b0, 8'h77);
        irq_is(1'b1, 3);
        rc(OFF_DATA, 8'h5A);
        rc(OFF_DATA, 8'h66);
        rc(OFF_LSTAT, 8'h00);
        // Receive trigger level with queues on and multidrop off.
        wr(OFF_LCTL, 8'h80);
        wr(OFF_FDM, 8'h00);
        wr(OFF_LCTL, 8'h00);
        wr(OFF_EFR, 8'h00);
        wr(OFF_IEN, 8'h01);
        wr(OFF_TRIG, 8'h02);
        i_umd_station.send(1'b0, 8'h01);
        irq_is(1'b0, 4);
        i_umd_station.send(1'b0, 8'h02);
        irq_is(1'b1, 4);
        rc(OFF_DATA, 8'h01);
        irq_is(1'b0, 3);
        rc(OFF_DATA, 8'h02);
        // Modem deltas, then the enhanced clear-to-send and request-to-send edges.
        wr(OFF_IEN, 8'h08);
        cts_n <= 1'b0;
        irq_is(1'b1, 8);
        rc(OFF_MSTAT, 8'h11);
        irq_is(1'b0, 3);
        wr(OFF_EFR, 8'h10);
        wr(OFF_IEN, 8'h80);
        cts_n <= 1'b1;
        irq_is(1'b1, 8);
        rc(OFF_MSTAT, 8'h01);
        wr(OFF_IEN, 8'h40);
        rts_n_level <= 1'b0;
        irq_is(1'b0, 3);
        rts_n_level <= 1'b1;
        irq_is(1'b1, 4);
        // Transmit-ready event, then a flow-off character with a parity error.
        wr(OFF_IEN, 8'h02);
        tx_below_trig <= 1'b1;
        irq_is(1'b1, 3);
        wr(OFF_IEN, 8'h20);
        i_umd_station.send(1'b1, 8'h5A);
        irq_is(1'b1, 4);
        print_verdict;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        print_verdict;
    end
endmodule
